// *** pls_link_ctl_status.sv ***
`timescale 1ns/100ps

// Summary of operation
// (RULE1) Report lane count as one-hot six-bit code
// (RULE2) Unsupported width limit: echo limit value instead
// (RULE3) Supported limit, training failed: report zero
// (RULE4) Slot clock bit loaded by application, resets zero
// (RULE5) Bits 31, 30, 29 always read zero
// (RULE6) Bits 27 and 26 always read zero
// (RULE7) Width limit writable; invalid code keeps default
// (RULE8) Writes to read-only fields are ignored
module pls_link_ctl_status (
  // Clock and reset
  input  wire logic                            clk_in,
  input  wire logic                            rst_in,
  // Wishbone slave
  input  wire pls_pkg::pls_wb_req_t            wb_req_in,
  output pls_pkg::pls_wb_rsp_t                 wb_rsp_out,
  // Link status from the physical layer
  input  wire logic                            link_trained_in,
  input  wire logic [pls_pkg::PLS_WIDTH_W-1:0] link_width_in,
  // Application clocking strap
  input  wire logic                            slot_clk_load_in,
  input  wire logic                            slot_clk_value_in,
  // Controls toward the link
  output logic      [pls_pkg::PLS_WIDTH_W-1:0] max_width_out,
  output logic      [pls_pkg::PLS_WIDTH_W-1:0] lane_count_out,
  output logic                                 common_clk_out
);
  import pls_pkg::*;

  // ========================================================================
  // Helpers
  // ========================================================================
  function automatic logic width_ok(input logic [PLS_WIDTH_W-1:0] code);
    width_ok = (code == PLS_W_X1) || (code == PLS_W_X2) || (code == PLS_W_X4);
  endfunction

  function automatic logic [PLS_DATA_W-1:0] lane_merge(
    input logic [PLS_DATA_W-1:0] old_word,
    input logic [PLS_DATA_W-1:0] new_word,
    input logic [PLS_SEL_W-1:0]  sel
  );
    logic [PLS_DATA_W-1:0] res;
    res = old_word;
    for (int i = 0; i < PLS_SEL_W; i++) begin
      if (sel[i]) begin
        res[i*PLS_BYTE_W +: PLS_BYTE_W] = new_word[i*PLS_BYTE_W +: PLS_BYTE_W];
      end
    end
    lane_merge = res;
  endfunction

  // ========================================================================
  // State
  // ========================================================================
  logic [PLS_WIDTH_W-1:0] mlw_ff;
  logic [PLS_WIDTH_W-1:0] nxt_mlw;
  logic [PLS_WIDTH_W-1:0] lane_cnt_ff;
  logic [PLS_WIDTH_W-1:0] nxt_lane_cnt;
  logic [PLS_WIDTH_W-1:0] eff_width_ff;
  logic                   sclk_ff;
  logic                   ack_ff;
  logic [PLS_DATA_W-1:0]  rdat_ff;
  logic                   ack_ctst_ff;
  logic                   req_go;
  logic                   wr_cap;
  logic [PLS_DATA_W-1:0]  cap_word;
  logic [PLS_DATA_W-1:0]  ctst_word;
  logic [PLS_DATA_W-1:0]  cap_merged;
  logic [PLS_DATA_W-1:0]  rd_word;

  // ========================================================================
  // Bus decode
  // ========================================================================
  // Ack is registered, so each request answers one cycle later and
  // the ack drops on its own in the following cycle.
  assign req_go = wb_req_in.cyc && wb_req_in.stb && !ack_ff;
  assign wr_cap = req_go && wb_req_in.we && (wb_req_in.adr == PLS_OFF_LINK_CAP);

  always_comb begin
    cap_word = PLS_DATA_ZERO;
    cap_word[PLS_MLW_MSB:PLS_MLW_LSB] = mlw_ff;
  end

  always_comb begin
    ctst_word = PLS_DATA_ZERO;
    // (RULE1) Lane count field
    ctst_word[PLS_LANE_MSB:PLS_LANE_LSB] = lane_cnt_ff;
    // (RULE4) Slot clock bit
    ctst_word[PLS_SCLK_BIT] = sclk_ff;
    // (RULE5) Bandwidth, active bits zero
    ctst_word[PLS_AUTOBW_BIT] = 1'b0;
    ctst_word[PLS_BWMGT_BIT]  = 1'b0;
    ctst_word[PLS_DLLA_BIT]   = 1'b0;
    // (RULE6) Training, reserved zero
    ctst_word[PLS_TRAIN_BIT] = 1'b0;
    ctst_word[PLS_RSVD_BIT]  = 1'b0;
  end

  always_comb begin
    case (wb_req_in.adr)
      PLS_OFF_LINK_CAP:  rd_word = cap_word;
      PLS_OFF_LINK_CTST: rd_word = ctst_word;
      default:           rd_word = PLS_DATA_ZERO;
    endcase
  end

  // ========================================================================
  // Bus answer
  // ========================================================================
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req_go;
    end
  end

  // Unmapped reads return zero; unmapped writes are acked and dropped
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdat_ff <= PLS_DATA_ZERO;
    end else if (req_go && !wb_req_in.we) begin
      rdat_ff <= rd_word;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ack_ctst_ff <= 1'b0;
    end else begin
      ack_ctst_ff <= req_go && !wb_req_in.we && (wb_req_in.adr == PLS_OFF_LINK_CTST);
    end
  end

  assign wb_rsp_out.ack = ack_ff;
  assign wb_rsp_out.dat = rdat_ff;

  // ========================================================================
  // Width limit
  // ========================================================================
  always_comb begin
    cap_merged = lane_merge(cap_word, wb_req_in.dat, wb_req_in.sel);
    nxt_mlw    = mlw_ff;
    // (RULE7) Width limit write
    if (wr_cap) begin
      nxt_mlw = cap_merged[PLS_MLW_MSB:PLS_MLW_LSB];
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mlw_ff <= PLS_MLW_RST;
    end else begin
      mlw_ff <= nxt_mlw;
    end
  end

  // Reserved codes are stored as written so software reads them back,
  // but the link itself only ever sees a legal width.
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      eff_width_ff <= PLS_MLW_RST;
    end else begin
      // (RULE7) Invalid keeps default
      eff_width_ff <= width_ok(mlw_ff) ? mlw_ff : PLS_MLW_RST;
    end
  end

  assign max_width_out = eff_width_ff;

  // ========================================================================
  // Negotiated lane count
  // ========================================================================
  always_comb begin
    // (RULE2) Echo unsupported limit
    if (!width_ok(mlw_ff)) begin
      nxt_lane_cnt = mlw_ff;
    // (RULE3) Failed training reads zero
    end else if (!link_trained_in) begin
      nxt_lane_cnt = PLS_W_NONE;
    // (RULE1) Report negotiated width
    end else begin
      nxt_lane_cnt = link_width_in;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      lane_cnt_ff <= PLS_W_NONE;
    end else begin
      lane_cnt_ff <= nxt_lane_cnt;
    end
  end

  assign lane_count_out = lane_cnt_ff;

  // ========================================================================
  // Slot clock configuration
  // ========================================================================
  // (RULE8) Only the application loads it
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sclk_ff <= PLS_SCLK_RST;
    end else if (slot_clk_load_in) begin
      // (RULE4) Application loads value
      sclk_ff <= slot_clk_value_in;
    end
  end

  assign common_clk_out = sclk_ff;

  // ========================================================================
  // Checks
  // ========================================================================
  sequence s_cap_full_write;
    wb_req_in.cyc && wb_req_in.stb && wb_req_in.we && !ack_ff
      && (wb_req_in.adr == PLS_OFF_LINK_CAP) && wb_req_in.sel[0] && wb_req_in.sel[1];
  endsequence

  sequence s_ctst_write;
    wb_req_in.cyc && wb_req_in.stb && wb_req_in.we && !ack_ff
      && (wb_req_in.adr == PLS_OFF_LINK_CTST);
  endsequence

  sequence s_request;
    wb_req_in.cyc && wb_req_in.stb && !ack_ff;
  endsequence

  AST_LANE_TRAINED: assert property ( // (RULE1)
    @(posedge clk_in) disable iff (rst_in)
    width_ok(mlw_ff) && link_trained_in |=> lane_count_out == $past(link_width_in))
    else $error("Lane count does not follow trained width");

  AST_LANE_ECHO: assert property ( // (RULE2)
    @(posedge clk_in) disable iff (rst_in)
    !width_ok(mlw_ff) && $stable(mlw_ff) |=> lane_cnt_ff == $past(mlw_ff))
    else $error("Unsupported limit not echoed in lane count");

  AST_LANE_FAIL: assert property ( // (RULE3)
    @(posedge clk_in) disable iff (rst_in)
    width_ok(mlw_ff) && !link_trained_in |=> lane_cnt_ff == PLS_W_NONE)
    else $error("Untrained link does not report zero lanes");

  AST_SCLK_LOAD: assert property ( // (RULE4)
    @(posedge clk_in) disable iff (rst_in)
    slot_clk_load_in |=> common_clk_out == $past(slot_clk_value_in))
    else $error("Slot clock bit not loaded from application");

  AST_ZERO_HIGH: assert property ( // (RULE5)
    @(posedge clk_in) disable iff (rst_in)
    ack_ctst_ff |-> rdat_ff[PLS_AUTOBW_BIT:PLS_DLLA_BIT] == 3'h0)
    else $error("Unsupported status bits read non-zero");

  AST_ZERO_TRAIN: assert property ( // (RULE6)
    @(posedge clk_in) disable iff (rst_in)
    ack_ctst_ff |-> !rdat_ff[PLS_TRAIN_BIT] && !rdat_ff[PLS_RSVD_BIT]
      && rdat_ff[PLS_SCLK_BIT] == $past(sclk_ff))
    else $error("Training or reserved bit read non-zero");

  AST_MLW_WRITE: assert property ( // (RULE7)
    @(posedge clk_in) disable iff (rst_in)
    s_cap_full_write |=> ack_ff && mlw_ff == $past(wb_req_in.dat[PLS_MLW_MSB:PLS_MLW_LSB])
      ##1 max_width_out == (width_ok(mlw_ff) ? mlw_ff : PLS_MLW_RST))
    else $error("Width limit write not applied");

  AST_MLW_DEFAULT: assert property ( // (RULE7)
    @(posedge clk_in) disable iff (rst_in)
    !width_ok(mlw_ff) |=> max_width_out == PLS_MLW_RST)
    else $error("Invalid limit reached the link");

  AST_RO_WRITE: assert property ( // (RULE8)
    @(posedge clk_in) disable iff (rst_in)
    (s_ctst_write and !slot_clk_load_in) |=> $stable(sclk_ff) && $stable(mlw_ff))
    else $error("Write to read-only field changed state");

  AST_ACK_PULSE: assert property (
    @(posedge clk_in) disable iff (rst_in)
    s_request |=> ack_ff ##1 !ack_ff)
    else $error("Ack is not a one-cycle answer");

  // Read data was captured on the same edge that raised the ack, hence the past value
  AST_LANE_READ: assert property ( // (RULE1)
    @(posedge clk_in) disable iff (rst_in)
    ack_ctst_ff |-> rdat_ff[PLS_LANE_MSB:PLS_LANE_LSB] == $past(lane_cnt_ff))
    else $error("Lane count field differs from its register");

  // Lower control fields and link speed are not built, so they read zero
  AST_LOW_ZERO: assert property ( // (RULE8)
    @(posedge clk_in) disable iff (rst_in)
    ack_ctst_ff |-> rdat_ff[PLS_LANE_LSB-1:0] == '0)
    else $error("Unbuilt low fields read non-zero");

  AST_SCLK_HOLD: assert property ( // (RULE8)
    @(posedge clk_in) disable iff (rst_in)
    !slot_clk_load_in |=> $stable(common_clk_out))
    else $error("Slot clock bit changed without a load");

  AST_LIMIT_LEGAL: assert property ( // (RULE7)
    @(posedge clk_in) disable iff (rst_in)
    width_ok(max_width_out))
    else $error("Link was given an illegal width");

endmodule

// *** pls_pkg.sv ***
// ==========================================================================
// Link control and status register bank: shared definitions
// ==========================================================================
package pls_pkg;

  // ========================================================================
  // Bus geometry
  // ========================================================================
  localparam int PLS_ADDR_W = 12;
  localparam int PLS_DATA_W = 32;
  localparam int PLS_SEL_W  = 4;

  // ========================================================================
  // Register offsets (byte addresses)
  // ========================================================================
  localparam logic [PLS_ADDR_W-1:0] PLS_OFF_LINK_CAP  = 12'h04c;
  localparam logic [PLS_ADDR_W-1:0] PLS_OFF_LINK_CTST = 12'h050;

  // ========================================================================
  // Field layout
  // ========================================================================
  localparam int PLS_MLW_LSB      = 4;
  localparam int PLS_MLW_MSB      = 9;
  localparam int PLS_LANE_LSB     = 20;
  localparam int PLS_LANE_MSB     = 25;
  localparam int PLS_RSVD_BIT     = 26;
  localparam int PLS_TRAIN_BIT    = 27;
  localparam int PLS_SCLK_BIT     = 28;
  localparam int PLS_DLLA_BIT     = 29;
  localparam int PLS_BWMGT_BIT    = 30;
  localparam int PLS_AUTOBW_BIT   = 31;
  localparam int PLS_WIDTH_W      = 6;
  localparam int PLS_BYTE_W       = 8;

  // ========================================================================
  // Width codes and reset values
  // ========================================================================
  localparam logic [PLS_WIDTH_W-1:0] PLS_W_X1      = 6'h01;
  localparam logic [PLS_WIDTH_W-1:0] PLS_W_X2      = 6'h02;
  localparam logic [PLS_WIDTH_W-1:0] PLS_W_X4      = 6'h04;
  localparam logic [PLS_WIDTH_W-1:0] PLS_W_NONE    = 6'h00;
  localparam logic [PLS_WIDTH_W-1:0] PLS_MLW_RST   = 6'h04;
  localparam logic                   PLS_SCLK_RST  = 1'b0;
  localparam logic [PLS_DATA_W-1:0]  PLS_DATA_ZERO = 32'h0000_0000;

  // ========================================================================
  // Bus carriers
  // ========================================================================
  typedef struct packed {
    logic                  cyc;
    logic                  stb;
    logic                  we;
    logic [PLS_ADDR_W-1:0] adr;
    logic [PLS_SEL_W-1:0]  sel;
    logic [PLS_DATA_W-1:0] dat;
  } pls_wb_req_t;

  typedef struct packed {
    logic                  ack;
    logic [PLS_DATA_W-1:0] dat;
  } pls_wb_rsp_t;

endpackage

// *** pls_phy_model.sv ***
`timescale 1ns/100ps

// ==========================================================================
// Link partner: trains to the applied width limit
// ==========================================================================
module pls_phy_model (
  // Clock and reset
  input  wire logic                            clk_in,
  input  wire logic                            rst_in,
  // Controls from the register bank and the bench
  input  wire logic [pls_pkg::PLS_WIDTH_W-1:0] max_width_in,
  input  wire logic                            train_ok_in,
  // Status toward the register bank
  output logic                                 trained_out,
  output logic      [pls_pkg::PLS_WIDTH_W-1:0] width_out
);
  import pls_pkg::*;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      trained_out <= 1'b0;
      width_out   <= PLS_W_NONE;
    end else begin
      trained_out <= train_ok_in;
      // Failed training shows no width, never a stale one
      width_out   <= train_ok_in ? max_width_in : PLS_W_NONE;
    end
  end
endmodule

// *** pls_link_ctl_status_tb.sv ***
`timescale 1ns/100ps

module pls_link_ctl_status_tb;
  import pls_pkg::*;

  // ========================================================================
  // Signals
  // ========================================================================
  logic        clk_in     = 1'b0;
  logic        rst_in     = 1'b1;
  pls_wb_req_t req        = '0;
  pls_wb_rsp_t rsp;
  logic        train_ok   = 1'b1;
  logic        load       = 1'b0;
  logic        load_val   = 1'b0;
  logic        trained;
  logic        sclk;
  logic [5:0]  width;
  logic [5:0]  max_w;
  logic [5:0]  lanes;
  logic [31:0] rd;
  logic [5:0]  codes [7]  = '{6'h01, 6'h02, 6'h04, 6'h00, 6'h03, 6'h08, 6'h3f};
  int          n_errors   = 0;
  int          num_checks = 0;
  int          cycles     = 0;

  always #2.5 clk_in = ~clk_in;

  pls_link_ctl_status uut (
    .clk_in            (clk_in),
    .rst_in            (rst_in),
    .wb_req_in         (req),
    .wb_rsp_out        (rsp),
    .link_trained_in   (trained),
    .link_width_in     (width),
    .slot_clk_load_in  (load),
    .slot_clk_value_in (load_val),
    .max_width_out     (max_w),
    .lane_count_out    (lanes),
    .common_clk_out    (sclk)
  );

  pls_phy_model phy (
    .clk_in       (clk_in),
    .rst_in       (rst_in),
    .max_width_in (max_w),
    .train_ok_in  (train_ok),
    .trained_out  (trained),
    .width_out    (width)
  );

  // ========================================================================
  // Tasks
  // ========================================================================
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Classic single cycle; held until ack is sampled high
  task automatic wb(input logic we, input logic [11:0] adr, input logic [31:0] dat);
    @(posedge clk_in);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: dat};
    do @(posedge clk_in); while (rsp.ack !== 1'b1);
    rd = rsp.dat;
    req <= '0;
  endtask

  function automatic logic [5:0] exp_lane(logic [5:0] l, logic ok);
    return (l inside {PLS_W_X1, PLS_W_X2, PLS_W_X4}) ? (ok ? l : PLS_W_NONE) : l;
  endfunction

  function automatic logic [31:0] exp_word(logic [5:0] l, logic ok, logic s);
    return {3'b000, s, 2'b00, exp_lane(l, ok), 20'h00000};
  endfunction

  task automatic print_verdict;
    if (n_errors == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      print_verdict;
    end
  end

  // ========================================================================
  // Sequence
  // ========================================================================
  initial begin
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    wb(1'b0, PLS_OFF_LINK_CTST, 32'h0);
    check("reset word", rd, exp_word(PLS_W_X4, 1'b1, 1'b0));
    wb(1'b0, PLS_OFF_LINK_CAP, 32'h0);
    check("limit reset", rd, 32'h0000_0040);
    wb(1'b1, PLS_OFF_LINK_CTST, 32'hffff_ffff);
    wb(1'b0, PLS_OFF_LINK_CTST, 32'h0);
    check("ro word", rd, exp_word(PLS_W_X4, 1'b1, 1'b0));
    load     <= 1'b1;
    load_val <= 1'b1;
    @(posedge clk_in);
    load     <= 1'b0;
    load_val <= 1'b0;
    @(posedge clk_in);
    check("slot clk pin", {31'h0, sclk}, 32'h1);
    for (int i = 0; i < 7; i++) begin
      for (int k = 0; k < 2; k++) begin
        train_ok <= (k == 0);
        wb(1'b1, PLS_OFF_LINK_CAP, {22'h0, codes[i], 4'h0});
        repeat (3) @(posedge clk_in);
        wb(1'b0, PLS_OFF_LINK_CAP, 32'h0);
        check("limit", rd, {22'h0, codes[i], 4'h0});
        wb(1'b0, PLS_OFF_LINK_CTST, 32'h0);
        check("word", rd, exp_word(codes[i], k == 0, 1'b1));
        check("lane pin", {26'h0, lanes}, {26'h0, exp_lane(codes[i], k == 0)});
        check("applied", {26'h0, max_w}, (codes[i] inside {PLS_W_X1, PLS_W_X2, PLS_W_X4})
              ? {26'h0, codes[i]} : {26'h0, PLS_W_X4});
      end
    end
    wb(1'b1, 12'h100, 32'hffff_ffff);
    wb(1'b0, 12'h100, 32'h0);
    check("unmapped", rd, 32'h0);
    print_verdict;
  end
endmodule
